// [dtc_pkg.sv]
// Purpose: constants for the dual timer/counter with clock output
// Assumes: byte-wide register port, one system clock
// Notes: register offsets are byte addresses on the plain register port
// How it works
// - timer counts every 12 clocks, or every clock
// - count pin sampled per rate, high-then-low counts
// - increment lands the cycle after detection
// - mode 0 is 13-bit, rollover sets flag
// - count only when run and gate allows; with unit 0 split, unit 1 ignores run and high byte ignores gate
// - mode 1 is full 16-bit count
// - mode 2 low byte reloads from high byte
// - unit 1 in mode 3 holds its count
// - unit 0 mode 3 splits into two bytes
// - clock-out mode gives 50% square wave
// - output period is 2n times (256 minus reload)
// - clock-out overflow sets flag, no interrupt
// - unit 1 overflow feeds baud and clock-out
// - flags set by hardware, cleared on vector
// - run bits switch units on and off
// - mode register nibbles: unit 1 high, unit 0 low
// - mode field picks 13, 16, reload, split/stop
// - counter-select picks system clock or count pin
// - speed-select picks divide-by-12 or undivided clock
// - aux bits 1 and 0 enable clock outputs
package dtc_pkg;
    localparam logic [7:0] ADDR_RUN_FLAGS = 8'h88;
    localparam logic [7:0] ADDR_MODE = 8'h89;
    localparam logic [7:0] ADDR_U0_LO = 8'h8a;
    localparam logic [7:0] ADDR_U1_LO = 8'h8b;
    localparam logic [7:0] ADDR_U0_HI = 8'h8c;
    localparam logic [7:0] ADDR_U1_HI = 8'h8d;
    localparam logic [7:0] ADDR_AUX = 8'ha3;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // run/flag register bit positions, unit 1 sits two bits above unit 0
    localparam int BIT_RUN0 = 4;
    localparam int BIT_FLAG0 = 5;
    localparam int BIT_RUN1 = 6;
    localparam int BIT_FLAG1 = 7;
    // mode register nibble layout
    localparam int NIB_W = 4;
    localparam int NIB_GATE = 3;
    localparam int NIB_CT = 2;
    localparam int NIB_MODE_LSB = 0;
    // aux register bit positions
    localparam int BIT_CKOE0 = 0;
    localparam int BIT_SPEED0 = 2;
    // mode field codes
    localparam logic [1:0] MODE_13BIT = 2'h0;
    localparam logic [1:0] MODE_16BIT = 2'h1;
    localparam logic [1:0] MODE_RELOAD8 = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;
    // prescaler
    localparam int PRESCALE_CYCLES = 12;
    localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE_CYCLES - 1);
endpackage : dtc_pkg

// [dtc_timer.sv]
// Purpose: two 16-bit timer/counters with modes 0..3 and clock output
// Assumes: count and gate pins are asynchronous, register port is synchronous
// Notes: all outputs are registered
`timescale 1ns/1ns
module dtc_timer (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic unit0_count_pin,
    input wire logic unit1_count_pin,
    input wire logic unit0_gate_input_pin,
    input wire logic unit1_gate_input_pin,
    input wire logic unit0_int_ack,
    input wire logic unit1_int_ack,
    output logic unit0_irq_req,
    output logic unit1_irq_req,
    output logic unit0_clock_out_pin,
    output logic unit1_clock_out_pin,
    output logic baud_tick
);
    logic [3:0] pre_q;
    logic [3:0] pre_d;
    logic tick12;
    logic [7:0] mode_reg_q;
    logic [3:0] aux_q;
    logic [1:0] run_q;
    logic [1:0] flag_q;
    logic [1:0] flag_d;
    logic [1:0] flag_set;
    logic [1:0] ack;
    logic [1:0] irq_q;
    logic [1:0] cko_q;
    logic baud_q;
    logic [7:0] rdata_q;
    logic [7:0] lo_q [2];
    logic [7:0] hi_q [2];
    logic [1:0] cnt_pin;
    logic [1:0] gate_pin;
    logic [1:0] rate;
    logic [1:0] inc;
    logic [1:0] ovf_lo;
    logic [1:0] ovf_hi;
    logic [1:0] cko_mode;
    logic split0;
    logic hi0_inc;
    logic wr_flags;
    logic wr_mode;
    logic wr_aux;
    logic [7:0] flags_val;
    logic [7:0] rd_val;

    assign cnt_pin = {unit1_count_pin, unit0_count_pin};
    assign gate_pin = {unit1_gate_input_pin, unit0_gate_input_pin};
    assign ack = {unit1_int_ack, unit0_int_ack};

    // register decode
    assign wr_flags = reg_wr && (reg_addr == dtc_pkg::ADDR_RUN_FLAGS);
    assign wr_mode = reg_wr && (reg_addr == dtc_pkg::ADDR_MODE);
    assign wr_aux = reg_wr && (reg_addr == dtc_pkg::ADDR_AUX);

    // divide-by-12 enable
    assign tick12 = (pre_q == dtc_pkg::PRESCALE_LAST);
    assign pre_d = tick12 ? 4'h0 : pre_q + 4'h1;

    // unit 0 split mode borrows unit 1 run bit for its high byte
    assign split0 = (mode_reg_q[dtc_pkg::NIB_MODE_LSB +: 2] == dtc_pkg::MODE_SPLIT);
    assign hi0_inc = split0 && run_q[1] && rate[0];

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pre_q <= 4'h0;
        end else begin
            pre_q <= pre_d;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_unit
            logic cs1_q;
            logic cs2_q;
            logic gs1_q;
            logic gs2_q;
            logic samp_q;
            logic fall_q;
            logic gate_en;
            logic ct_en;
            logic run_eff;
            logic pulse;
            logic [1:0] mode;
            logic wr_lo;
            logic wr_hi;
            logic [7:0] lo_d;
            logic [7:0] hi_d;
            logic ol;
            logic oh;
            logic [7:0] lo_r;
            logic [7:0] hi_r;
            logic cko_r;
            logic irq_r;

            // one process owns each unit's flops; the shared vectors only mirror them
            assign lo_q[i] = lo_r;
            assign hi_q[i] = hi_r;
            assign cko_q[i] = cko_r;
            assign irq_q[i] = irq_r;

            assign mode = mode_reg_q[i*dtc_pkg::NIB_W + dtc_pkg::NIB_MODE_LSB +: 2];
            assign gate_en = mode_reg_q[i*dtc_pkg::NIB_W + dtc_pkg::NIB_GATE];
            assign ct_en = mode_reg_q[i*dtc_pkg::NIB_W + dtc_pkg::NIB_CT];
            assign rate[i] = aux_q[dtc_pkg::BIT_SPEED0 + i] ? 1'b1 : tick12;
            assign cko_mode[i] = !ct_en && aux_q[dtc_pkg::BIT_CKOE0 + i];
            // unit 1 runs free while unit 0 is in split mode and borrows its run bit
            assign run_eff = (i == 1 && split0) ? 1'b1 : run_q[i];
            assign pulse = ct_en ? fall_q : rate[i];
            assign inc[i] = run_eff && (!gate_en || gs2_q) && pulse;
            assign wr_lo = reg_wr && (reg_addr == (i == 0 ? dtc_pkg::ADDR_U0_LO : dtc_pkg::ADDR_U1_LO));
            assign wr_hi = reg_wr && (reg_addr == (i == 0 ? dtc_pkg::ADDR_U0_HI : dtc_pkg::ADDR_U1_HI));
            assign ovf_lo[i] = ol;
            assign ovf_hi[i] = oh;

            // pin synchronisers and falling-edge sampling at the rate
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    cs1_q <= 1'b0;
                    cs2_q <= 1'b0;
                    gs1_q <= 1'b0;
                    gs2_q <= 1'b0;
                    samp_q <= 1'b0;
                    fall_q <= 1'b0;
                end else begin
                    cs1_q <= cnt_pin[i];
                    cs2_q <= cs1_q;
                    gs1_q <= gate_pin[i];
                    gs2_q <= gs1_q;
                    if (rate[i]) begin
                        samp_q <= cs2_q;
                    end
                    fall_q <= rate[i] && samp_q && !cs2_q;
                end
            end

            always_comb begin
                lo_d = lo_q[i];
                hi_d = hi_q[i];
                ol = 1'b0;
                oh = 1'b0;
                if (cko_mode[i]) begin
                    if (inc[i]) begin
                        if (&lo_q[i]) begin
                            lo_d = hi_q[i];
                            ol = 1'b1;
                        end else begin
                            lo_d = lo_q[i] + 8'h01;
                        end
                    end
                end else begin
                    unique case (mode)
                        dtc_pkg::MODE_13BIT: begin
                            if (inc[i]) begin
                                {hi_d, lo_d[4:0]} = {hi_q[i], lo_q[i][4:0]} + 13'h0001;
                                ol = &{hi_q[i], lo_q[i][4:0]};
                            end
                        end
                        dtc_pkg::MODE_16BIT: begin
                            if (inc[i]) begin
                                {hi_d, lo_d} = {hi_q[i], lo_q[i]} + 16'h0001;
                                ol = &{hi_q[i], lo_q[i]};
                            end
                        end
                        dtc_pkg::MODE_RELOAD8: begin
                            if (inc[i]) begin
                                if (&lo_q[i]) begin
                                    lo_d = hi_q[i];
                                    ol = 1'b1;
                                end else begin
                                    lo_d = lo_q[i] + 8'h01;
                                end
                            end
                        end
                        dtc_pkg::MODE_SPLIT: begin
                            if (i == 0) begin
                                if (inc[i]) begin
                                    lo_d = lo_q[i] + 8'h01;
                                    ol = &lo_q[i];
                                end
                                if (hi0_inc) begin
                                    hi_d = hi_q[i] + 8'h01;
                                    oh = &hi_q[i];
                                end
                            end
                            // unit 1 keeps lo_d and hi_d unchanged here
                        end
                    endcase
                end
                if (wr_lo) begin
                    lo_d = reg_wdata;
                end
                if (wr_hi) begin
                    hi_d = reg_wdata;
                end
            end

            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    lo_r <= dtc_pkg::RESET_BYTE;
                    hi_r <= dtc_pkg::RESET_BYTE;
                    cko_r <= 1'b0;
                    irq_r <= 1'b0;
                end else begin
                    lo_r <= lo_d;
                    hi_r <= hi_d;
                    if (!cko_mode[i]) begin
                        cko_r <= 1'b0;
                    end else if (ovf_lo[i]) begin
                        cko_r <= !cko_r;
                    end
                    irq_r <= flag_d[i] && !cko_mode[i];
                end
            end
        end
    endgenerate

    // flag sources; hardware set wins over any clear
    assign flag_set[0] = ovf_lo[0];
    assign flag_set[1] = split0 ? ovf_hi[0] : ovf_lo[1];
    assign flag_d[0] = flag_set[0] || (wr_flags ? reg_wdata[dtc_pkg::BIT_FLAG0] : (flag_q[0] && !ack[0]));
    assign flag_d[1] = flag_set[1] || (wr_flags ? reg_wdata[dtc_pkg::BIT_FLAG1] : (flag_q[1] && !ack[1]));

    // run/flag register image, low nibble reads zero
    assign flags_val = {flag_q[1], run_q[1], flag_q[0], run_q[0], 4'h0};

    assign rd_val = (reg_addr == dtc_pkg::ADDR_RUN_FLAGS) ? flags_val :
                    (reg_addr == dtc_pkg::ADDR_MODE) ? mode_reg_q :
                    (reg_addr == dtc_pkg::ADDR_U0_LO) ? lo_q[0] :
                    (reg_addr == dtc_pkg::ADDR_U1_LO) ? lo_q[1] :
                    (reg_addr == dtc_pkg::ADDR_U0_HI) ? hi_q[0] :
                    (reg_addr == dtc_pkg::ADDR_U1_HI) ? hi_q[1] :
                    (reg_addr == dtc_pkg::ADDR_AUX) ? {4'h0, aux_q} :
                    8'h00;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mode_reg_q <= dtc_pkg::RESET_BYTE;
            aux_q <= 4'h0;
            run_q <= 2'h0;
            flag_q <= 2'h0;
            baud_q <= 1'b0;
            rdata_q <= dtc_pkg::RESET_BYTE;
        end else begin
            if (wr_mode) begin
                mode_reg_q <= reg_wdata;
            end
            if (wr_aux) begin
                aux_q <= reg_wdata[3:0];
            end
            if (wr_flags) begin
                run_q <= {reg_wdata[dtc_pkg::BIT_RUN1], reg_wdata[dtc_pkg::BIT_RUN0]};
            end
            flag_q <= flag_d;
            baud_q <= ovf_lo[1];
            rdata_q <= reg_rd ? rd_val : 8'h00;
        end
    end

    assign reg_rdata = rdata_q;
    assign unit0_irq_req = irq_q[0];
    assign unit1_irq_req = irq_q[1];
    assign unit0_clock_out_pin = cko_q[0];
    assign unit1_clock_out_pin = cko_q[1];
    assign baud_tick = baud_q;
endmodule // dtc_timer

// [dtc_monitor.sv]
// Purpose: port checker for the dual timer
// Assumes: mode and aux bytes change only by software writes
// Notes: bound into every dtc_timer
`timescale 1ns/1ns
module dtc_monitor (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic unit0_irq_req,
    input wire logic unit1_irq_req,
    input wire logic unit0_clock_out_pin,
    input wire logic unit1_clock_out_pin,
    input wire logic baud_tick
);
    logic [7:0] mode_q;
    logic [7:0] aux_q;
    logic ck0_on;
    logic ck1_on;
    assign ck0_on = aux_q[0] && !mode_q[2];
    assign ck1_on = aux_q[1] && !mode_q[6];
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mode_q <= 8'h00;
            aux_q <= 8'h00;
        end else if (reg_wr && reg_addr == dtc_pkg::ADDR_MODE) begin
            mode_q <= reg_wdata;
        end else if (reg_wr && reg_addr == dtc_pkg::ADDR_AUX) begin
            aux_q <= reg_wdata;
        end
    end
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    clk0_off_a: assert property (!ck0_on && !$past(ck0_on) |-> !unit0_clock_out_pin)
        else $error("clock out 0 active outside its mode");
    clk1_off_a: assert property (!ck1_on && !$past(ck1_on) |-> !unit1_clock_out_pin)
        else $error("clock out 1 active outside its mode");
    irq0_quiet_a: assert property (ck0_on && $past(ck0_on) |-> !unit0_irq_req)
        else $error("unit 0 request in clock out mode");
    irq1_quiet_a: assert property (ck1_on && $past(ck1_on) |-> !unit1_irq_req)
        else $error("unit 1 request in clock out mode");
    baud_clk_a: assert property (ck1_on && $past(ck1_on) && $past(ck1_on, 2)
        |-> (unit1_clock_out_pin != $past(unit1_clock_out_pin)) == baud_tick)
        else $error("baud tick and clock out 1 disagree");
    run_back_a: assert property (reg_wr && reg_addr == dtc_pkg::ADDR_RUN_FLAGS
        ##2 reg_rd && reg_addr == dtc_pkg::ADDR_RUN_FLAGS
        |=> reg_rdata[6] == $past(reg_wdata[6], 3) && reg_rdata[4] == $past(reg_wdata[4], 3))
        else $error("run bits read back wrong");
    mode_back_a: assert property ($past(reg_rd) && $past(reg_addr) == dtc_pkg::ADDR_MODE
        |-> reg_rdata == mode_q)
        else $error("mode byte read back wrong");
    aux_back_a: assert property ($past(reg_rd) && $past(reg_addr) == dtc_pkg::ADDR_AUX
        |-> reg_rdata == {4'h0, aux_q[3:0]})
        else $error("aux byte read back wrong");
endmodule // dtc_monitor
bind dtc_timer dtc_monitor u_dtc_monitor (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .unit0_irq_req, .unit1_irq_req, .unit0_clock_out_pin, .unit1_clock_out_pin, .baud_tick);

// [dtc_pin_model.sv]
// Purpose: far side count and gate pins
// Assumes: pins idle high
// Notes: each level held 16 clocks, longer than one rate period
`timescale 1ns/1ns
module dtc_pin_model (
    input wire logic sys_clk,
    output logic unit0_count_pin,
    output logic unit0_gate_input_pin,
    output logic unit1_count_pin,
    output logic unit1_gate_input_pin
);
    initial begin
        unit0_count_pin = 1'b1;
        unit0_gate_input_pin = 1'b1;
        unit1_count_pin = 1'b1;
        unit1_gate_input_pin = 1'b1;
    end
    task automatic pulses(input int n);
        repeat (n) begin
            repeat (16) @(posedge sys_clk);
            unit0_count_pin <= 1'b0;
            repeat (16) @(posedge sys_clk);
            unit0_count_pin <= 1'b1;
        end
    endtask
    task automatic set_gate(input logic lvl);
        @(posedge sys_clk);
        unit0_gate_input_pin <= lvl;
    endtask
endmodule // dtc_pin_model

// [testbench.sv]
// Purpose: self-checking bench for dtc_timer
// Assumes: 125 MHz clock, pin model on the far side
// Notes: bus tasks start and end just after a rising edge
`timescale 1ns/1ns
module testbench;
    logic sys_clk, rst_n, reg_wr, reg_rd, unit0_int_ack, unit1_int_ack, baud_tick;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
    logic unit0_count_pin, unit1_count_pin, unit0_gate_input_pin, unit1_gate_input_pin;
    logic unit0_irq_req, unit1_irq_req, unit0_clock_out_pin, unit1_clock_out_pin;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    int w;
    logic [7:0] regs [8] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'ha3, 8'h55};
    // mode, high, low, then high and low expected after two counts
    logic [39:0] rows [3] = '{40'h00ffbe00a0, 40'h01fffe0000, 40'h025afe5a5a};
    dtc_timer u_dtc_timer (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .unit0_count_pin, .unit1_count_pin, .unit0_gate_input_pin, .unit1_gate_input_pin,
        .unit0_int_ack, .unit1_int_ack, .unit0_irq_req, .unit1_irq_req, .unit0_clock_out_pin,
        .unit1_clock_out_pin, .baud_tick);
    dtc_pin_model u_dtc_pin_model (.sys_clk, .unit0_count_pin, .unit0_gate_input_pin,
        .unit1_count_pin, .unit1_gate_input_pin);
    task automatic end_of_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask
    task automatic run_for(input logic [7:0] r, input int n);
        wr(8'h88, r);
        repeat (n - 2) @(posedge sys_clk);
        wr(8'h88, 8'h00);
    endtask
    task automatic ack();
        unit0_int_ack <= 1'b1;
        unit1_int_ack <= 1'b1;
        @(posedge sys_clk);
        unit0_int_ack <= 1'b0;
        unit1_int_ack <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic width(input bit u, input logic lvl, output int n);
        n = 0;
        while ((u ? unit1_clock_out_pin : unit0_clock_out_pin) === lvl) @(posedge sys_clk);
        while ((u ? unit1_clock_out_pin : unit0_clock_out_pin) !== lvl) @(posedge sys_clk);
        while ((u ? unit1_clock_out_pin : unit0_clock_out_pin) === lvl) begin
            n++;
            @(posedge sys_clk);
        end
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            end_of_test();
        end
    end
    initial begin
        {rst_n, reg_wr, reg_rd, unit0_int_ack, unit1_int_ack} = '0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        foreach (regs[i]) begin
            rd(regs[i], v);
            check(v, 8'h00);
        end
        wr(8'ha3, 8'h04);
        foreach (rows[i]) begin
            wr(8'h89, rows[i][39:32]);
            wr(8'h8c, rows[i][31:24]);
            wr(8'h8a, rows[i][23:16]);
            run_for(8'h10, 2);
            rd(8'h8c, v);
            check(v, rows[i][15:8]);
            rd(8'h8a, v);
            check(v, rows[i][7:0]);
            rd(8'h88, v);
            check(v, 8'h20);
            check({7'h0, unit0_irq_req}, 8'h01);
            ack();
            rd(8'h88, v);
            check(v, 8'h00);
        end
        wr(8'ha3, 8'h00);
        wr(8'h8a, 8'h00);
        run_for(8'h10, 120);
        rd(8'h8a, v);
        check(v, 8'h0a);
        wr(8'ha3, 8'h04);
        wr(8'h8a, 8'h00);
        run_for(8'h10, 50);
        rd(8'h8a, v);
        check(v, 8'h32);
        wr(8'h88, 8'h5f);
        rd(8'h88, v);
        check(v, 8'h50);
        wr(8'ha3, 8'h00);
        wr(8'h89, 8'h0d);
        wr(8'h8a, 8'h00);
        wr(8'h8c, 8'h00);
        u_dtc_pin_model.set_gate(1'b0);
        wr(8'h88, 8'h10);
        u_dtc_pin_model.pulses(3);
        repeat (40) @(posedge sys_clk);
        rd(8'h8a, v);
        check(v, 8'h00);
        u_dtc_pin_model.set_gate(1'b1);
        u_dtc_pin_model.pulses(3);
        repeat (40) @(posedge sys_clk);
        rd(8'h8a, v);
        check(v, 8'h03);
        wr(8'ha3, 8'h0f);
        wr(8'h89, 8'h00);
        wr(8'h8c, 8'hfc);
        wr(8'h8a, 8'hfc);
        wr(8'h8d, 8'hfa);
        wr(8'h8b, 8'hfa);
        wr(8'h88, 8'h50);
        width(1'b0, 1'b1, w);
        check(w[7:0], 8'h04);
        width(1'b0, 1'b0, w);
        check(w[7:0], 8'h04);
        width(1'b1, 1'b1, w);
        check(w[7:0], 8'h06);
        rd(8'h88, v);
        check(v & 8'ha0, 8'ha0);
        check({6'h0, unit1_irq_req, unit0_irq_req}, 8'h00);
        wr(8'h88, 8'h00);
        wr(8'ha3, 8'h0c);
        wr(8'h88, 8'h00);
        rd(8'h88, v);
        check(v, 8'h00);
        wr(8'h89, 8'h33);
        wr(8'h8a, 8'hfe);
        wr(8'h8c, 8'hfe);
        wr(8'h8b, 8'h77);
        run_for(8'h50, 2);
        rd(8'h8a, v);
        check(v, 8'h00);
        rd(8'h8c, v);
        check(v, 8'h00);
        rd(8'h8b, v);
        check(v, 8'h77);
        rd(8'h88, v);
        check(v, 8'ha0);
        check({7'h0, unit1_irq_req}, 8'h01);
        rd(8'h89, v);
        check(v, 8'h33);
        ack();
        rd(8'h88, v);
        check(v, 8'h00);
        end_of_test();
    end
endmodule // testbench
